// File: hdl/rcs_reset_cause_status.sv
/*
  Reset-cause status block: watches the reset requests of the chip, issues
  a system reset, and records in a read-only byte what caused it. Also
  holds the illegal-address capture and a small config byte.
  Assumes rst is the power-on reset of this block's own domain, and that
  requests from pins or other domains are asynchronous levels.
//
// How it works
// [RL1] Power-on flag is 1 after power-on reset, 0 after any other reset.
// [RL2] Pin flag set when external active-low reset pin caused the reset.
// [RL3] Watchdog flag set on watchdog timeout; blocked while timeout select is 00.
// [RL4] Illegal opcode flag set when an illegal instruction caused the reset.
// [RL5] Stop instruction is illegal while stop enable is 0.
// [RL6] Background instruction is illegal while background mode enable is 0.
// [RL7] Illegal address flag set and offending address captured high and low.
// [RL8] Clock-source flag set when the internal clock source requested reset.
// [RL9] Low-voltage flag 1 on power-on and low-voltage resets, 0 otherwise.
// [RL10] Low-voltage flag read as 1 means low-voltage trip or power-on.
// [RL11] Flash fault flag set on illegal flash access reset.
// [RL12] All flags readable as read-only status of the most recent reset.
// [RL13] Debug forced reset leaves every flag cleared.
// [RL14] Pin, watchdog and opcode flags reflect every source active at reset.
// [RL15] Software writes never change the flags; only the next reset does.
*/
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "rcs_params.svh"
module rcs_reset_cause_status
#(
  parameter int ADDR_WIDTH = 16,
  parameter int HOLD_CYCLES = 16
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  reset_pin_n,
  input  wire logic                  watchdog_timeout,
  input  wire logic                  low_voltage_reset,
  input  wire logic                  clock_source_reset,
  input  wire logic                  flash_access_fault,
  input  wire logic                  debug_forced_reset,
  input  wire logic                  exec_strobe,
  input  wire logic                  exec_illegal,
  input  wire logic                  exec_stop,
  input  wire logic                  exec_background,
  input  wire logic                  background_mode_enable,
  input  wire logic                  illegal_access,
  input  wire logic [ADDR_WIDTH-1:0] illegal_access_addr,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  output logic                       system_reset,
  output logic                       stop_enable,
  output logic      [1:0]            watchdog_timeout_select
);

  // ****************************************
  // Request synchronisation
  // ****************************************
  // Pins and foreign-domain requests pass two flops before use
  // Each request must stay up for two clocks at least or it may be missed
  logic [5:0] async_req;
  logic [5:0] sync_req;

  assign async_req = {~reset_pin_n, watchdog_timeout, low_voltage_reset,
                      clock_source_reset, flash_access_fault, debug_forced_reset};

  rcs_sync
  #(
    .WIDTH (6)
  )
  u_sync
  (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (async_req),
    .sync_out (sync_req)
  );

  logic pin_req;
  logic wdog_req;
  logic lowv_req;
  logic clk_req;
  logic flash_req;
  logic dbg_req;

  assign pin_req   = sync_req[5];
  assign wdog_req  = sync_req[4];
  assign lowv_req  = sync_req[3];
  assign clk_req   = sync_req[2];
  assign flash_req = sync_req[1];
  assign dbg_req   = sync_req[0];

  // ****************************************
  // Config byte
  // ****************************************
  // Only rst clears the config; a system reset keeps the software settings
  logic [7:0] config_r;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      config_r <= `RCS_CFG_RESET;
    else if (reg_wr && reg_addr == `RCS_OFS_CONFIG)
      config_r <= reg_wdata;
  end

  assign stop_enable             = config_r[`RCS_CFG_STOP_EN];
  assign watchdog_timeout_select = config_r[`RCS_CFG_WDOG_HI:`RCS_CFG_WDOG_LO];

  // ****************************************
  // Request decode
  // ****************************************
  logic wdog_hit;
  logic opcode_hit;
  logic any_req;

  // A blocked watchdog neither resets the chip nor leaves a flag
  assign wdog_hit = wdog_req && (watchdog_timeout_select != `RCS_WDOG_BLOCKED);  // [RL3]

  // Core signals are on this clock, so they need no synchroniser
  assign opcode_hit = exec_strobe &&
                      (exec_illegal ||
                       (exec_stop && !stop_enable) ||                      // [RL5]
                       (exec_background && !background_mode_enable));      // [RL6]

  assign any_req = pin_req || wdog_hit || lowv_req || clk_req || flash_req ||
                   dbg_req || opcode_hit || illegal_access;

  // ****************************************
  // Reset sequencer
  // ****************************************
  rcs_pkg::rcs_state_type state_r;
  rcs_pkg::rcs_state_type state_nxt;
  logic [$clog2(HOLD_CYCLES+1)-1:0] hold_cnt_r;
  logic [7:0]                        cause_acc_r;
  logic                              dbg_seen_r;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      rcs_pkg::RCS_RUN:
        if (any_req)
          state_nxt = rcs_pkg::RCS_HOLD;
      rcs_pkg::RCS_HOLD:
        // A pin or low-voltage request still up keeps the chip in reset
        if (hold_cnt_r == '0 && !pin_req && !lowv_req)
          state_nxt = rcs_pkg::RCS_REPORT;
      rcs_pkg::RCS_REPORT:
        state_nxt = rcs_pkg::RCS_RUN;
      default:
        state_nxt = rcs_pkg::RCS_RUN;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state_r <= rcs_pkg::RCS_HOLD;
    else
      state_r <= state_nxt;
  end

  // Reloaded on every run cycle, so each reset entered from run holds the full count; the power-on reset starts at zero
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      hold_cnt_r <= '0;
    else if (state_r == rcs_pkg::RCS_RUN)
      hold_cnt_r <= ($clog2(HOLD_CYCLES+1))'(HOLD_CYCLES);
    else if (hold_cnt_r != '0)
      hold_cnt_r <= hold_cnt_r - 1'b1;
  end

  assign system_reset = (state_r != rcs_pkg::RCS_RUN);

  // Gather every source seen while the reset is pending, illegal opcodes and
  // illegal accesses only from run; a sticky accumulator keeps short pulses that end during the hold
  function automatic logic [7:0] cause_bits
  (
    input logic pin,
    input logic wdog,
    input logic opc,
    input logic ila,
    input logic clk,
    input logic lowv,
    input logic flash
  );
    logic [7:0] b;
    b = `RCS_STATUS_ZERO;
    b[`RCS_BIT_PIN]        = pin;        // [RL2] [RL14]
    b[`RCS_BIT_WATCHDOG]   = wdog;       // [RL3] [RL14]
    b[`RCS_BIT_ILL_OPCODE] = opc;        // [RL4] [RL14]
    b[`RCS_BIT_ILL_ADDR]   = ila;        // [RL7]
    b[`RCS_BIT_CLK_SRC]    = clk;        // [RL8]
    b[`RCS_BIT_LOW_VOLT]   = lowv;       // [RL9] [RL10]
    b[`RCS_BIT_FLASH]      = flash;      // [RL11]
    return b;
  endfunction

  logic [7:0] cause_now;

  assign cause_now = cause_bits(pin_req, wdog_hit, opcode_hit && state_r == rcs_pkg::RCS_RUN,
                                illegal_access && state_r == rcs_pkg::RCS_RUN,
                                clk_req, lowv_req, flash_req);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cause_acc_r <= `RCS_STATUS_ZERO;
    else if (state_r == rcs_pkg::RCS_REPORT)
      cause_acc_r <= `RCS_STATUS_ZERO;
    else if (state_r == rcs_pkg::RCS_HOLD || any_req)
      cause_acc_r <= cause_acc_r | cause_now;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      dbg_seen_r <= 1'b0;
    else if (state_r == rcs_pkg::RCS_REPORT)
      dbg_seen_r <= 1'b0;
    else if (dbg_req && (state_r == rcs_pkg::RCS_HOLD || any_req))
      dbg_seen_r <= 1'b1;
  end

  // ****************************************
  // Power-on marker
  // ****************************************
  // The power-on sequence also ends through REPORT; without this marker
  // the empty accumulator would wipe the power-on flags there
  logic por_pending_r;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      por_pending_r <= 1'b1;
    else if (state_r == rcs_pkg::RCS_REPORT)
      por_pending_r <= 1'b0;
  end

  // ****************************************
  // Status byte and illegal-address capture
  // ****************************************
  logic [7:0]            status_r;
  logic [ADDR_WIDTH-1:0] ill_addr_r;

  // Software writes never reach this register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      status_r <= `RCS_STATUS_POR;                                     // [RL1] [RL9]
    else if (state_r == rcs_pkg::RCS_REPORT)
    begin
      // Debug forced reset wins over every other cause of the same sequence
      if (dbg_seen_r)
        status_r <= `RCS_STATUS_ZERO;                                  // [RL13]
      else if (por_pending_r)
        status_r <= cause_acc_r | `RCS_STATUS_POR;                     // [RL1] [RL9] [RL10]
      else
        status_r <= cause_acc_r;                                       // [RL1] [RL12] [RL15]
    end
  end

  // Only the access that starts a reset is kept; later ones are ignored
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ill_addr_r <= '0;
    else if (illegal_access && state_r == rcs_pkg::RCS_RUN)
      ill_addr_r <= illegal_access_addr;                               // [RL7]
  end

  // ****************************************
  // Register read port
  // ****************************************
  // Narrower capture widths are zero-extended into the two bytes
  // Idle reads return zero so several ports can be ORed onto one bus
  logic [15:0] addr_wide;

  assign addr_wide = 16'(ill_addr_r);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      reg_rdata <= `RCS_RD_ZERO;
    else if (reg_rd)
    begin
      case (reg_addr)
        `RCS_OFS_STATUS:    reg_rdata <= status_r;                     // [RL12]
        `RCS_OFS_ADDR_HIGH: reg_rdata <= addr_wide[15:8];
        `RCS_OFS_ADDR_LOW:  reg_rdata <= addr_wide[7:0];
        `RCS_OFS_CONFIG:    reg_rdata <= config_r;
        default:            reg_rdata <= `RCS_RD_ZERO;
      endcase
    end
    else
      reg_rdata <= `RCS_RD_ZERO;
  end

endmodule

// File: hdl/rcs_params.svh
/*
  Constants for the reset-cause status block: bit positions, reset values,
  register offsets of the local port.
  Assumes inclusion by the status module and the testbench, not by rcs_pkg.sv.
*/
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH

// ****************************************
// Register offsets on the local port
// ****************************************
`define RCS_OFS_STATUS    8'h00
`define RCS_OFS_ADDR_HIGH 8'h01
`define RCS_OFS_ADDR_LOW  8'h02
`define RCS_OFS_CONFIG    8'h03

// ****************************************
// Status byte bit positions
// ****************************************
`define RCS_BIT_POWER_ON   7
`define RCS_BIT_PIN        6
`define RCS_BIT_WATCHDOG   5
`define RCS_BIT_ILL_OPCODE 4
`define RCS_BIT_ILL_ADDR   3
`define RCS_BIT_CLK_SRC    2
`define RCS_BIT_LOW_VOLT   1
`define RCS_BIT_FLASH      0

// ****************************************
// Config byte bit positions and values
// ****************************************
`define RCS_CFG_STOP_EN    0
`define RCS_CFG_WDOG_LO    2
`define RCS_CFG_WDOG_HI    3
`define RCS_CFG_RESET      8'h00
`define RCS_WDOG_BLOCKED   2'h0

// ****************************************
// Reset values
// ****************************************
`define RCS_STATUS_POR     8'h82
`define RCS_STATUS_ZERO    8'h00
`define RCS_ADDR_ZERO      16'h0000
`define RCS_RD_ZERO        8'h00

`endif

// File: hdl/rcs_pkg.sv
/*
  Types for the reset-cause status block.
  Assumes nothing beyond the constants header.
*/
package rcs_pkg;

  // Sequencer states, one-hot
  typedef enum logic [2:0]
  {
    RCS_RUN    = 3'b001,
    RCS_HOLD   = 3'b010,
    RCS_REPORT = 3'b100
  } rcs_state_type;

endpackage

// File: hdl/rcs_sync.sv
/*
  Two-flop synchroniser for a vector of asynchronous levels.
  Assumes the inputs are slow levels; multi-bit skew is tolerated since
  each bit is an independent request.
*/
`timescale 1ns/10ps
module rcs_sync
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// File: tb/rcs_checker_sva.sv
/*
  Checker for the reset-cause status block: each cause but the debug forced reset must start a reset.
  Assumes bind to rcs_reset_cause_status; async causes take 2 sync cycles.
*/
`timescale 1ns/10ps
module rcs_checker
#(
  parameter int ADDR_WIDTH  = 16,
  parameter int HOLD_CYCLES = 16
)
(
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire logic                  reset_pin_n,
  input wire logic                  watchdog_timeout,
  input wire logic                  low_voltage_reset,
  input wire logic                  clock_source_reset,
  input wire logic                  flash_access_fault,
  input wire logic                  exec_strobe,
  input wire logic                  exec_illegal,
  input wire logic                  exec_stop,
  input wire logic                  exec_background,
  input wire logic                  background_mode_enable,
  input wire logic                  illegal_access,
  input wire logic [7:0]            reg_addr,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  system_reset,
  input wire logic                  stop_enable,
  input wire logic [1:0]            watchdog_timeout_select
);
  // ****************************************
  // Causes and status
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_pin_cause: assert property (!reset_pin_n && !system_reset |-> ##[1:4] system_reset)
    else $error("pin low gave no reset");
  a_wdog_cause: assert property (watchdog_timeout && watchdog_timeout_select != 2'h0
    && !system_reset |-> ##[1:4] system_reset) else $error("watchdog gave no reset");
  a_opcode_cause: assert property (exec_strobe && exec_illegal && !system_reset
    |=> system_reset) else $error("illegal opcode gave no reset");
  a_stop_cause: assert property (exec_strobe && exec_stop && !stop_enable && !system_reset
    |=> system_reset) else $error("disabled stop gave no reset");
  a_background_cause: assert property (exec_strobe && exec_background
    && !background_mode_enable && !system_reset |=> system_reset)
    else $error("disabled background gave no reset");
  a_addr_cause: assert property (illegal_access && !system_reset |=> system_reset)
    else $error("illegal access gave no reset");
  a_clk_cause: assert property (clock_source_reset && !system_reset
    |-> ##[1:4] system_reset) else $error("clock source gave no reset");
  a_low_volt_cause: assert property (low_voltage_reset && !system_reset
    |-> ##[1:4] system_reset) else $error("low voltage gave no reset");
  a_flash_cause: assert property (flash_access_fault && !system_reset
    |-> ##[1:4] system_reset) else $error("flash fault gave no reset");
  a_status_ro: assert property ((reg_rd && reg_addr == 8'h00)
    ##1 (reg_wr && reg_addr == 8'h00) ##1 (reg_rd && reg_addr == 8'h00 && !system_reset)
    |=> reg_rdata == $past(reg_rdata, 2)) else $error("status changed by a write");
endmodule

bind rcs_reset_cause_status rcs_checker #(.ADDR_WIDTH(ADDR_WIDTH), .HOLD_CYCLES(HOLD_CYCLES)) chk (
  .ref_clk(ref_clk), .rst(rst), .reset_pin_n(reset_pin_n), .watchdog_timeout(watchdog_timeout),
  .low_voltage_reset(low_voltage_reset), .clock_source_reset(clock_source_reset),
  .flash_access_fault(flash_access_fault), .exec_strobe(exec_strobe),
  .exec_illegal(exec_illegal), .exec_stop(exec_stop), .exec_background(exec_background),
  .background_mode_enable(background_mode_enable), .illegal_access(illegal_access),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .system_reset(system_reset), .stop_enable(stop_enable),
  .watchdog_timeout_select(watchdog_timeout_select));

// File: tb/testbench.sv
/*
  Self-checking bench: fires each reset cause and reads the status byte.
  Assumes HOLD_CYCLES of 4 and the offsets of rcs_params.svh.
*/
`timescale 1ns/10ps
`include "rcs_params.svh"
module testbench;
  logic ref_clk = 0, rst = 1, reset_pin_n = 1, watchdog_timeout = 0, low_voltage_reset = 0;
  logic clock_source_reset = 0, flash_access_fault = 0, debug_forced_reset = 0;
  logic exec_strobe = 0, exec_illegal = 0, exec_stop = 0, exec_background = 0;
  logic background_mode_enable = 0, illegal_access = 0, reg_wr = 0, reg_rd = 0;
  logic [15:0] illegal_access_addr = 16'h0000;
  logic [15:0] addr_exp;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, d, last;
  logic [7:0]  reg_rdata;
  logic [1:0]  watchdog_timeout_select;
  logic        system_reset, stop_enable;
  int          err_count = 0, compares = 0, seed = 41, k;

  always #20 ref_clk = ~ref_clk;

  rcs_reset_cause_status #(.ADDR_WIDTH(16), .HOLD_CYCLES(4)) uut (
    .ref_clk(ref_clk), .rst(rst), .reset_pin_n(reset_pin_n), .watchdog_timeout(watchdog_timeout),
    .low_voltage_reset(low_voltage_reset), .clock_source_reset(clock_source_reset),
    .flash_access_fault(flash_access_fault), .debug_forced_reset(debug_forced_reset),
    .exec_strobe(exec_strobe), .exec_illegal(exec_illegal), .exec_stop(exec_stop),
    .exec_background(exec_background), .background_mode_enable(background_mode_enable),
    .illegal_access(illegal_access), .illegal_access_addr(illegal_access_addr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .system_reset(system_reset), .stop_enable(stop_enable),
    .watchdog_timeout_select(watchdog_timeout_select));

  // ****************************************
  // Shared tasks
  // ****************************************
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task test_done;
    $display("compares=%0d mismatches=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Bounded wait for the reset output to reach a level
  task wait_rst(input logic lvl);
    int n;
    n = 0;
    while (system_reset !== lvl)
    begin
      if (n++ > 200)
      begin
        err_count++;
        test_done;
      end
      @(posedge ref_clk);
      #1;
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge ref_clk);
    reg_rd <= 0;
    #1 v = reg_rdata;
  endtask

  // Opcode causes share one flag; debug with pin must leave all clear
  function logic [7:0] expect_status(input int c);
    case (c)
      0: return 8'h01 << `RCS_BIT_PIN;
      1: return 8'h01 << `RCS_BIT_WATCHDOG;
      2: return 8'h01 << `RCS_BIT_LOW_VOLT;
      3: return 8'h01 << `RCS_BIT_CLK_SRC;
      4: return 8'h01 << `RCS_BIT_FLASH;
      5, 6, 7: return 8'h01 << `RCS_BIT_ILL_OPCODE;
      8: return 8'h01 << `RCS_BIT_ILL_ADDR;
      10: return (8'h01 << `RCS_BIT_PIN) | (8'h01 << `RCS_BIT_WATCHDOG);
      default: return 8'h00;
    endcase
  endfunction

  // Levels held past the synchroniser, pulses one cycle wide
  task fire(input int c);
    wr(`RCS_OFS_CONFIG, 8'h0C);
    @(posedge ref_clk);
    case (c)
      0: reset_pin_n <= 0;
      1: watchdog_timeout <= 1;
      2: low_voltage_reset <= 1;
      3: clock_source_reset <= 1;
      4: flash_access_fault <= 1;
      8: illegal_access <= 1;
      9: {debug_forced_reset, reset_pin_n} <= 2'b10;
      10: {reset_pin_n, watchdog_timeout} <= 2'b01;
      default:
        {exec_strobe, exec_illegal, exec_stop, exec_background} <= {1'b1, c == 5, c == 6, c == 7};
    endcase
    addr_exp = 16'($random(seed));
    illegal_access_addr <= addr_exp;
    @(posedge ref_clk);
    {exec_strobe, exec_illegal, exec_stop, exec_background, illegal_access} <= 5'h00;
    repeat (3) @(posedge ref_clk);
    {reset_pin_n, watchdog_timeout, low_voltage_reset} <= 3'b100;
    {clock_source_reset, flash_access_fault, debug_forced_reset} <= 3'b000;
    wait_rst(1);
    wait_rst(0);
    rd(`RCS_OFS_STATUS, d);
    last = expect_status(c);
    check(d, last);
    if (c == 8)
    begin
      rd(`RCS_OFS_ADDR_HIGH, d);
      check(d, addr_exp[15:8]);
      rd(`RCS_OFS_ADDR_LOW, d);
      check(d, addr_exp[7:0]);
    end
  endtask

  // Release reset and expect the power-on and low-voltage flags
  task por_check;
    rst <= 0;
    wait_rst(0);
    rd(`RCS_OFS_STATUS, d);
    check(d, (8'h01 << `RCS_BIT_POWER_ON) | (8'h01 << `RCS_BIT_LOW_VOLT));
    $display("power-on check done");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge ref_clk);
    por_check;
    for (k = 0; k < 11; k++)
      fire(k);
    repeat (6) fire($unsigned($random(seed)) % 11);
    $display("cause loop done");
    wr(`RCS_OFS_CONFIG, 8'h01);
    #1 check(stop_enable, 1'b1);
    check(watchdog_timeout_select, 2'h0);
    @(posedge ref_clk);
    {watchdog_timeout, background_mode_enable, exec_strobe, exec_stop} <= 4'hF;
    @(posedge ref_clk);
    {exec_strobe, exec_stop} <= 2'b10;
    exec_background <= 1;
    @(posedge ref_clk);
    {exec_strobe, exec_background} <= 2'b00;
    repeat (6) @(posedge ref_clk);
    watchdog_timeout <= 0;
    #1 check(system_reset, 1'b0);
    $display("blocked causes done");
    @(posedge ref_clk);
    reg_addr <= `RCS_OFS_STATUS;
    reg_wdata <= 8'hFF;
    reg_rd <= 1;
    @(posedge ref_clk);
    {reg_rd, reg_wr} <= 2'b01;
    #1 check(reg_rdata, last);
    @(posedge ref_clk);
    {reg_rd, reg_wr} <= 2'b10;
    #1 check(reg_rdata, 8'h00);
    @(posedge ref_clk);
    reg_rd <= 0;
    #1 check(reg_rdata, last);
    rd(8'h10, d);
    check(d, 8'h00);
    $display("register access done");
    @(posedge ref_clk);
    rst <= 1;
    repeat (2) @(posedge ref_clk);
    por_check;
    check(stop_enable, 1'b0);
    test_done;
  end
endmodule
